// ### dsc_pkg.sv
package dsc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned DW      = 16;   // Sample word width
	localparam int unsigned FDEPTH  = 8;    // Pair buffer entries
	localparam int unsigned PTR_W   = 3;    // Pair buffer pointer width
	localparam int unsigned DLY_MAX = 3;    // Deepest output delay

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;  // Path and sync control
	localparam logic [7:0] ADDR_MODE  = 8'h04;  // Filter stage modes
	localparam logic [7:0] ADDR_GAIN  = 8'h08;  // Channel gains
	localparam logic [7:0] ADDR_OFSA  = 8'h0c;  // Programmed offset A
	localparam logic [7:0] ADDR_OFSB  = 8'h10;  // Programmed offset B
	localparam logic [7:0] ADDR_ERR   = 8'h14;  // Sticky errors and masks
	localparam logic [7:0] ADDR_OSYNC = 8'h18;  // Offset transfer strobe
	localparam logic [7:0] ADDR_STAT  = 8'h1c;  // Live pointer state

	// ----------------------------------------------------------------
	// Control word bit positions
	// ----------------------------------------------------------------
	localparam int unsigned C_FMT_OB   = 0;   // Offset binary input
	localparam int unsigned C_REVERSE  = 1;   // Bit order reversal
	localparam int unsigned C_SWAP     = 2;   // Channel swap
	localparam int unsigned C_DUP      = 3;   // Channel duplicate
	localparam int unsigned C_SINGLE   = 4;   // Single converter mode
	localparam int unsigned C_OFS_EN   = 5;   // Offset add enable
	localparam int unsigned C_SLEEP_A  = 6;   // First channel sleep
	localparam int unsigned C_SLEEP_B  = 7;   // Second channel sleep
	localparam int unsigned C_SDO_INV  = 8;   // Serial out inversion
	localparam int unsigned C_FOURWIRE = 9;   // Four-wire serial port
	localparam int unsigned C_SOFT_SEL = 10;  // Software sync source
	localparam int unsigned C_SOFT     = 11;  // Software sync level
	localparam int unsigned C_HOLD_EN  = 12;  // Sync resets hold logic
	localparam int unsigned C_CDIV_EN  = 13;  // Sync resets divider
	localparam int unsigned C_FIFO_EN  = 14;  // Sync loads pointer
	localparam int unsigned C_TEST_EN  = 15;  // Self test enable
	localparam int unsigned C_TRAIN    = 16;  // Setup/hold check mode
	localparam int unsigned C_FACT_A   = 17;  // Factory test bit
	localparam int unsigned C_FACT_AN  = 18;  // Factory analog test
	localparam int unsigned C_FOFS_LO  = 19;  // Pointer offset, 3 bits
	localparam int unsigned C_DLY_LO   = 22;  // Output delay, 2 bits
	localparam int unsigned CTRL_W     = 24;  // Implemented bits

	// ----------------------------------------------------------------
	// Error register bit positions
	// ----------------------------------------------------------------
	localparam int unsigned E_TEST  = 0;  // Self test error
	localparam int unsigned E_FIFO  = 1;  // Pair buffer error
	localparam int unsigned E_SH    = 2;  // Setup/hold error
	localparam int unsigned E_MASK  = 4;  // Masks start here

	// ----------------------------------------------------------------
	// Reset values and training words
	// ----------------------------------------------------------------
	localparam logic [CTRL_W-1:0] CTRL_RST = 24'h007000;  // Syncs enabled
	localparam logic [5:0]        MODE_RST = 6'h00;       // Both bypass
	localparam logic [7:0]        GAIN_RST = 8'hff;       // Full scale
	localparam logic [7:0]        LFSR_RST = 8'h01;       // Test seed
	localparam logic [DW-1:0]     TRAIN_0  = 16'haaaa;    // Training word
	localparam logic [DW-1:0]     TRAIN_1  = 16'h5555;    // Training word
	localparam logic [PTR_W-1:0]  PTR_GAP  = 3'h4;        // Nominal gap

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DW-1:0] a;  // First channel sample
		logic [DW-1:0] b;  // Second channel sample
	} dsc_pair_t;

	typedef struct packed {
		logic [DW-1:0]             din_m;     // Data pin first stage
		logic [DW-1:0]             din_s;     // Data pin second stage
		logic                      sync_m;    // Sync pin first stage
		logic                      sync_s;    // Sync pin second stage
		logic                      src_d;     // Last sync source level
		logic [CTRL_W-1:0]         ctrl;      // Control word
		logic [5:0]                mode;      // Stage modes
		logic [7:0]                gain;      // Gains B:A
		dsc_pair_t                 ofs_prog;  // Programmed offsets
		dsc_pair_t                 ofs_work;  // Working offsets
		logic [2:0]                mask;      // Error masks
		logic [2:0]                flag;      // Sticky errors
		logic                      err;       // Any error pending
		logic                      phase;     // Interleave phase
		logic [DW-1:0]             hold_a;    // Held first word
		logic [FDEPTH-1:0][2*DW-1:0] mem;     // Pair buffer
		logic [PTR_W-1:0]          wptr;      // Buffer write pointer
		logic [PTR_W-1:0]          rptr;      // Buffer read pointer
		logic [DLY_MAX-1:0][2*DW-1:0] dly;    // Output delay line
		dsc_pair_t                 dac;       // Converter outputs
		logic                      txen;      // Transmit enable
		logic                      cdiv;      // Divider sync pulse
		logic [7:0]                lfsr_a;    // Test pattern copy A
		logic [7:0]                lfsr_b;    // Test pattern copy B
		logic                      pready;    // Bus answer
		logic                      pslverr;   // Bus error answer
		logic [31:0]               prdata;    // Bus read data
	} dsc_state_t;

endpackage

// ### dsc_top.sv
// What this block does
// RULE1 - Accept two's complement or offset binary words
// RULE2 - Optionally reverse input word bit order
// RULE3 - Optionally swap A and B paths
// RULE4 - Optionally copy first channel to second
// RULE5 - Sync loads read pointer with offset
// RULE6 - Delay both outputs zero to three cycles
// RULE7 - Two stage mode fields shared by channels
// RULE8 - Dual interleaved or single; separate sleep
// RULE9 - Per channel sixteen step gain
// RULE10 - Add per channel offsets when enabled
// RULE11 - Offsets take effect only on offset sync
// RULE12 - Masks suppress each error kind
// RULE13 - Sticky self test error until cleared
// RULE14 - Sticky buffer overrun error until cleared
// RULE15 - Only training words; others set sticky error
// RULE16 - Serial output polarity selectable
// RULE17 - Three or four wire serial port
// RULE18 - Software source ignores external sync pin
// RULE19 - Software bit drives sync and transmit
// RULE20 - Enables choose what sync resets
// RULE21 - Self test runs when enabled
// RULE22 - Software keeps factory test bits off
// RULE23 - Registered sync applies resets together
//
// The APB register port and the register addresses were left to the implementer.
module dsc_top
(
	input  wire logic                    core_clk_i,          // System clock
	input  wire logic                    reset_n_i,           // Async reset
	input  wire logic                    psel_i,              // APB select
	input  wire logic                    penable_i,           // APB enable
	input  wire logic                    pwrite_i,            // APB write
	input  wire logic [7:0]              paddr_i,             // APB address
	input  wire logic [31:0]             pwdata_i,            // APB write data
	output logic                         pready_o,            // APB ready
	output logic                         pslverr_o,           // APB error
	output logic [31:0]                  prdata_o,            // APB read data
	input  wire logic [dsc_pkg::DW-1:0]  lvds_data_i,         // Data pins
	input  wire logic                    sync_pin_i,          // Sync pin
	output logic [dsc_pkg::DW-1:0]       first_converter_channel_o,
	output logic [dsc_pkg::DW-1:0]       second_converter_channel_o,
	output logic [2:0]                   first_stage_mode_o,  // Stage one
	output logic [2:0]                   second_stage_mode_o, // Stage two
	output logic                         sleep_first_o,       // Sleep A
	output logic                         sleep_second_o,      // Sleep B
	output logic                         sdo_invert_o,        // SDO polarity
	output logic                         four_wire_o,         // Port mode
	output logic                         tx_enable_o,         // Transmit
	output logic                         clk_div_sync_o,      // Divider sync
	output logic                         factory_test_bit_a_o,
	output logic                         factory_analog_test_o,
	output logic                         error_o              // Any error
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dsc_pkg::dsc_state_t s;       // Registered state
	dsc_pkg::dsc_state_t next_s;  // Next state

	// Reverse bit order of a word
	function automatic logic [dsc_pkg::DW-1:0] rev_word(input logic [dsc_pkg::DW-1:0] w);
		logic [dsc_pkg::DW-1:0] r;
		r = '0;
		for (int i = 0; i < dsc_pkg::DW; i++)
		begin
			r[i] = w[dsc_pkg::DW-1-i];
		end
		return r;
	endfunction

	// Scale a sample by (gain + 1) / 16
	function automatic logic [dsc_pkg::DW-1:0] scale(input logic [dsc_pkg::DW-1:0] x,
	                                                  input logic [3:0] g);
		logic signed [21:0] p;
		p = 22'($signed(x) * $signed({2'h0, g} + 6'h01));
		return p[19:4];
	endfunction

	// Advance a test pattern
	function automatic logic [7:0] lfsr_step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic                    src;        // Selected sync source level
	logic                    sync_ev;    // Registered sync event
	logic [dsc_pkg::DW-1:0]  word;       // Formatted input word
	logic                    pair_wr;    // A pair enters the buffer
	logic                    setup;      // Bus setup cycle
	logic                    acc_wr;     // Bus write completes
	logic                    hit;        // Address mapped
	logic [31:0]             rmux;       // Read data
	logic [2:0]              set_f;      // Error set events
	logic [2:0]              clr_f;      // Error clears
	logic                    osync_wr;   // Offset transfer strobe
	dsc_pkg::dsc_pair_t      rd;         // Pair leaving the buffer
	dsc_pkg::dsc_pair_t      proc;       // Processed pair
	logic [1:0]              dly_sel;    // Selected delay
	logic [2:0]              fofs;       // Pointer offset field

	// ----------------------------------------------------------------
	// Next state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s   = s;
		set_f    = '0;
		clr_f    = '0;
		osync_wr = 1'b0;
		rmux     = '0;
		hit      = 1'b1;
		// Pin synchronisers
		next_s.din_m  = lvds_data_i;
		next_s.din_s  = s.din_m;
		next_s.sync_m = sync_pin_i;
		next_s.sync_s = s.sync_m;
		// Sync source selection
		src = s.ctrl[dsc_pkg::C_SOFT_SEL] ? s.ctrl[dsc_pkg::C_SOFT]  // see RULE18
		                                  : s.sync_s;
		next_s.src_d = src;
		sync_ev      = src & ~s.src_d;                        // see RULE23
		next_s.txen  = src;                                   // see RULE19
		next_s.cdiv  = sync_ev & s.ctrl[dsc_pkg::C_CDIV_EN];  // see RULE20
		// Input word conditioning
		word = s.din_s;
		if (s.ctrl[dsc_pkg::C_REVERSE])
		begin
			word = rev_word(word);  // see RULE2
		end
		if (s.ctrl[dsc_pkg::C_FMT_OB])
		begin
			word[dsc_pkg::DW-1] = ~word[dsc_pkg::DW-1];  // see RULE1
		end
		// Training word check on the raw received word
		if (s.ctrl[dsc_pkg::C_TRAIN] && s.din_s != dsc_pkg::TRAIN_0
		    && s.din_s != dsc_pkg::TRAIN_1)
		begin
			set_f[dsc_pkg::E_SH] = 1'b1;  // see RULE15
		end
		// Interleave pairing
		pair_wr = 1'b0;
		if (s.ctrl[dsc_pkg::C_SINGLE])
		begin
			// Every word is a first channel sample
			pair_wr                                = 1'b1;  // see RULE8
			next_s.mem[s.wptr]                     = {word, {dsc_pkg::DW{1'b0}}};
		end
		else if (!s.phase)
		begin
			// First word of an interleaved pair
			next_s.hold_a = word;
			next_s.phase  = 1'b1;
		end
		else
		begin
			// Second word completes the pair
			pair_wr            = 1'b1;  // see RULE8
			next_s.mem[s.wptr] = {s.hold_a, word};
			next_s.phase       = 1'b0;
		end
		if (sync_ev && s.ctrl[dsc_pkg::C_HOLD_EN])
		begin
			next_s.phase = 1'b0;  // see RULE20
		end
		// Buffer pointers and overrun check
		rd = s.mem[s.rptr];
		if (pair_wr)
		begin
			next_s.wptr = s.wptr + 3'h1;
			next_s.rptr = s.rptr + 3'h1;
			if (s.wptr == s.rptr)
			begin
				set_f[dsc_pkg::E_FIFO] = 1'b1;  // see RULE14
			end
		end
		fofs = s.ctrl[dsc_pkg::C_FOFS_LO +: 3];
		if (sync_ev && s.ctrl[dsc_pkg::C_FIFO_EN])
		begin
			// Taken from the write pointer after this cycle's write
			next_s.rptr = next_s.wptr + dsc_pkg::PTR_GAP + fofs;  // see RULE5
		end
		// Channel routing
		proc = rd;
		if (s.ctrl[dsc_pkg::C_SWAP])
		begin
			proc = {rd.b, rd.a};  // see RULE3
		end
		if (s.ctrl[dsc_pkg::C_DUP])
		begin
			proc.b = proc.a;  // see RULE4
		end
		if (s.ctrl[dsc_pkg::C_OFS_EN])
		begin
			proc.a = proc.a + s.ofs_work.a;  // see RULE10
			proc.b = proc.b + s.ofs_work.b;
		end
		proc.a = scale(proc.a, s.gain[3:0]);  // see RULE9
		proc.b = scale(proc.b, s.gain[7:4]);
		// Output delay line, same depth for both channels
		dly_sel = s.ctrl[dsc_pkg::C_DLY_LO +: 2];
		if (pair_wr)
		begin
			next_s.dly[0] = proc;
			for (int i = 1; i < dsc_pkg::DLY_MAX; i++)
			begin
				next_s.dly[i] = s.dly[i-1];
			end
			if (dly_sel == 2'h0)
			begin
				next_s.dac = proc;  // see RULE6
			end
			else
			begin
				next_s.dac = s.dly[dly_sel - 2'h1];  // see RULE6
			end
		end
		// Self test: two pattern copies must agree
		if (s.ctrl[dsc_pkg::C_TEST_EN])
		begin
			next_s.lfsr_a = lfsr_step(s.lfsr_a);  // see RULE21
			next_s.lfsr_b = lfsr_step(s.lfsr_b);
			if (s.lfsr_a != s.lfsr_b)
			begin
				set_f[dsc_pkg::E_TEST] = 1'b1;  // see RULE13
			end
		end
		// Bus address decode and read mux
		case (paddr_i)
			dsc_pkg::ADDR_CTRL:  rmux = 32'(s.ctrl);
			dsc_pkg::ADDR_MODE:  rmux = 32'(s.mode);
			dsc_pkg::ADDR_GAIN:  rmux = 32'(s.gain);
			dsc_pkg::ADDR_OFSA:  rmux = 32'(s.ofs_prog.a);
			dsc_pkg::ADDR_OFSB:  rmux = 32'(s.ofs_prog.b);
			dsc_pkg::ADDR_ERR:   rmux = 32'({s.mask, 1'b0, s.flag});
			dsc_pkg::ADDR_OSYNC: rmux = 32'h0;
			dsc_pkg::ADDR_STAT:  rmux = 32'({s.phase, s.rptr, 1'b0, s.wptr});
			default:             hit  = 1'b0;
		endcase
		// Bus handshake, answer one cycle after setup
		setup  = psel_i & ~penable_i & ~s.pready;
		acc_wr = psel_i & penable_i & s.pready & pwrite_i & hit;
		next_s.pready = setup;
		if (setup)
		begin
			next_s.prdata  = pwrite_i ? 32'h0 : rmux;
			next_s.pslverr = ~hit;
		end
		if (acc_wr)
		begin
			case (paddr_i)
				dsc_pkg::ADDR_CTRL: next_s.ctrl       = pwdata_i[dsc_pkg::CTRL_W-1:0];
				dsc_pkg::ADDR_MODE: next_s.mode       = pwdata_i[5:0];  // see RULE7
				dsc_pkg::ADDR_GAIN: next_s.gain       = pwdata_i[7:0];
				dsc_pkg::ADDR_OFSA: next_s.ofs_prog.a = pwdata_i[dsc_pkg::DW-1:0];
				dsc_pkg::ADDR_OFSB: next_s.ofs_prog.b = pwdata_i[dsc_pkg::DW-1:0];
				dsc_pkg::ADDR_ERR:
				begin
					clr_f       = pwdata_i[2:0];
					next_s.mask = pwdata_i[dsc_pkg::E_MASK +: 3];
				end
				dsc_pkg::ADDR_OSYNC: osync_wr = pwdata_i[0];
				default:             clr_f    = '0;
			endcase
		end
		// Offset transfer on request only
		if (osync_wr)
		begin
			next_s.ofs_work = s.ofs_prog;  // see RULE11
		end
		// Sticky errors, set wins over clear, masked kinds never set
		next_s.flag = (s.flag & ~clr_f) | (set_f & ~s.mask);  // see RULE12
		// Summary flop so the error output needs no gate
		next_s.err  = |next_s.flag;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s        <= '0;
			s.ctrl   <= dsc_pkg::CTRL_RST;
			s.mode   <= dsc_pkg::MODE_RST;
			s.gain   <= dsc_pkg::GAIN_RST;
			s.lfsr_a <= dsc_pkg::LFSR_RST;
			s.lfsr_b <= dsc_pkg::LFSR_RST;
			s.rptr   <= dsc_pkg::PTR_GAP;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from state flops
	// ----------------------------------------------------------------
	assign pready_o                   = s.pready;
	assign pslverr_o                  = s.pslverr;
	assign prdata_o                   = s.prdata;
	assign first_converter_channel_o  = s.dac.a;
	assign second_converter_channel_o = s.dac.b;
	assign first_stage_mode_o         = s.mode[2:0];  // see RULE7
	assign second_stage_mode_o        = s.mode[5:3];
	assign sleep_first_o              = s.ctrl[dsc_pkg::C_SLEEP_A];
	assign sleep_second_o             = s.ctrl[dsc_pkg::C_SLEEP_B];  // see RULE8
	assign sdo_invert_o               = s.ctrl[dsc_pkg::C_SDO_INV];  // see RULE16
	assign four_wire_o                = s.ctrl[dsc_pkg::C_FOURWIRE];  // see RULE17
	assign tx_enable_o                = s.txen;
	assign clk_div_sync_o             = s.cdiv;
	assign factory_test_bit_a_o       = s.ctrl[dsc_pkg::C_FACT_A];
	assign factory_analog_test_o      = s.ctrl[dsc_pkg::C_FACT_AN];
	assign error_o                    = s.err;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence seq_setup;
		psel_i && !penable_i && !s.pready;
	endsequence

	sequence seq_pulse_once;
		s.cdiv ##1 !s.cdiv;
	endsequence

	a_bus_answer_once: assert property (seq_setup |=> s.pready ##1 !s.pready)
		else $error("bus answer not a single cycle");

	a_bus_unmapped_err: assert property (seq_setup and !hit |=> s.pready && s.pslverr)
		else $error("unmapped address not refused");

	a_divider_sync_pulse: assert property (  // see RULE20
		sync_ev && s.ctrl[dsc_pkg::C_CDIV_EN] |=> seq_pulse_once)
		else $error("divider sync pulse wrong");

	a_fifo_ptr_load: assert property (  // see RULE5
		sync_ev && s.ctrl[dsc_pkg::C_FIFO_EN]
		|=> s.rptr == 3'(s.wptr + dsc_pkg::PTR_GAP + $past(fofs)))
		else $error("read pointer not loaded from offset");

	a_offset_on_sync: assert property (!$stable(s.ofs_work) |-> $past(osync_wr))  // see RULE11
		else $error("working offset changed without transfer");

	a_train_err_set: assert property (  // see RULE15
		s.ctrl[dsc_pkg::C_TRAIN] && !s.mask[dsc_pkg::E_SH]
		&& s.din_s != dsc_pkg::TRAIN_0 && s.din_s != dsc_pkg::TRAIN_1
		|=> s.flag[dsc_pkg::E_SH] ##1 s.flag[dsc_pkg::E_SH] || $past(clr_f[dsc_pkg::E_SH]))
		else $error("setup/hold error not held");

	a_fifo_overrun_flag: assert property (  // see RULE14
		pair_wr && s.wptr == s.rptr && !s.mask[dsc_pkg::E_FIFO] |=> s.flag[dsc_pkg::E_FIFO])
		else $error("overrun not flagged");

	a_soft_sync_only: assert property (  // see RULE18
		s.ctrl[dsc_pkg::C_SOFT_SEL] |=> tx_enable_o == $past(s.ctrl[dsc_pkg::C_SOFT]))
		else $error("external sync pin leaked through");

	a_pin_sync_txen: assert property (  // see RULE19
		!s.ctrl[dsc_pkg::C_SOFT_SEL] |=> tx_enable_o == $past(s.sync_s))
		else $error("transmit enable not following sync pin");

	a_mask_blocks_flag: assert property (  // see RULE12
		(s.flag & ~$past(s.flag) & $past(s.mask)) == 3'h0)
		else $error("masked error reported");

	a_flag_sticky_hold: assert property (  // see RULE13 RULE14
		($past(s.flag) & ~s.flag & ~$past(clr_f)) == 3'h0)
		else $error("sticky error dropped without clear");

	a_delay_zero_path: assert property (pair_wr && dly_sel == 2'h0 |=> s.dac == $past(proc))  // see RULE6
		else $error("zero delay output wrong");

endmodule // dsc_top

// ### dsc_src.sv
// ----------------------------------------------------------------
// Parallel word source facing the data pins
// ----------------------------------------------------------------
module dsc_src
(
	input  wire logic        clk_i,   // Word clock
	input  wire logic        train_i, // Send training words only
	input  wire logic        bad_i,   // Inject one stray word
	input  wire logic [15:0] word_i,  // Constant sample word
	output logic      [15:0] data_o   // Data pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog; // Training word select
	initial tog = 1'b0;
	initial data_o = 16'h0000;
	// One word each clock
	always @(posedge clk_i)
	begin
		tog <= ~tog;
		if (bad_i)
			data_o <= 16'h1234;
		else if (train_i)
			data_o <= tog ? 16'haaaa : 16'h5555;
		else
			data_o <= word_i;
	end
endmodule // dsc_src

// ### dsc_top_tb.sv
// ----------------------------------------------------------------
// Self-checking bench for the converter front end
// ----------------------------------------------------------------
module dsc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, psel, pen, pwr, pready, perr, e, sync, train, bad;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] word, a_o, b_o, din, x, o, pa, pb;
	logic [2:0]  m1, m2;
	logic        sla, slb, sdo, fw, txen, cdiv, fa, fan, err;
	logic [23:0] cfg [6] = '{24'h0, 24'h1, 24'hc00002, 24'h400010, 24'h18, 24'h14};
	int          fails, checks, seed, cyc, npulse;
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	dsc_top u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.pslverr_o(perr), .prdata_o(prdata), .lvds_data_i(din), .sync_pin_i(sync),
		.first_converter_channel_o(a_o), .second_converter_channel_o(b_o),
		.first_stage_mode_o(m1), .second_stage_mode_o(m2), .sleep_first_o(sla),
		.sleep_second_o(slb), .sdo_invert_o(sdo), .four_wire_o(fw), .tx_enable_o(txen),
		.clk_div_sync_o(cdiv), .factory_test_bit_a_o(fa), .factory_analog_test_o(fan),
		.error_o(err));
	dsc_src u_src (.clk_i(clk), .train_i(train), .bad_i(bad), .word_i(word), .data_o(din));
	// Pulse counter and hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cdiv === 1'b1)
			npulse++;
		if (cyc == 20000)
		begin
			fails++;
			conclude();
		end
	end
	task conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until ready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// Expected first channel for a constant input word
	function logic [15:0] exp_a(input logic [23:0] c, input logic [15:0] v, input logic [15:0] f);
		logic [15:0] r;
		r = v;
		if (c[1])
			for (int i = 0; i < 16; i++)
				r[i] = v[15-i];
		if (c[0])
			r[15] = ~r[15];
		if (c[5])
			r = r + f;
		return r;
	endfunction
	// Expected sample after a gain of (g + 1) / 16
	function logic [15:0] exp_g(input logic [15:0] v, input int g);
		return 16'(($signed(v) * (g + 1)) >>> 4);
	endfunction
	// Main sequence
	initial
	begin
		seed = 12114;
		{fails, checks, cyc, npulse} = '0;
		{psel, pen, pwr, sync, train, bad, rst_n} = '0;
		{paddr, pwdata, word} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, dsc_pkg::ADDR_CTRL, 0); chk(rd, 32'(dsc_pkg::CTRL_RST));
		apb(1'b0, dsc_pkg::ADDR_GAIN, 0); chk(rd, 32'(dsc_pkg::GAIN_RST));
		apb(1'b0, 8'h20, 0); chk({31'h0, e}, 32'h1);
		$display("test registers done");
		foreach (cfg[k])
		begin
			x = 16'($random(seed));
			word <= x;
			apb(1'b1, dsc_pkg::ADDR_CTRL, {8'h0, dsc_pkg::CTRL_RST | cfg[k]});
			repeat (40) @(posedge clk);
			pa = exp_a(cfg[k], x, 0);
			pb = cfg[k][4] ? 16'h0 : pa;
			if (cfg[k][2])
				{pa, pb} = {pb, pa};
			if (cfg[k][3])
				pb = pa;
			chk(a_o, pa);
			chk(b_o, pb);
		end
		o = 16'($random(seed));
		apb(1'b1, dsc_pkg::ADDR_OFSA, o);
		apb(1'b1, dsc_pkg::ADDR_OFSB, {16'h0, ~o});
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h7020);
		repeat (40) @(posedge clk);
		chk(a_o, x);
		chk(b_o, x);
		apb(1'b1, dsc_pkg::ADDR_OSYNC, 1);
		repeat (40) @(posedge clk);
		chk(a_o, 16'(x + o));
		chk(b_o, 16'(x + ~o));
		apb(1'b1, dsc_pkg::ADDR_GAIN, 32'h37);
		repeat (40) @(posedge clk);
		chk(a_o, exp_g(16'(x + o), 7));
		chk(b_o, exp_g(16'(x + ~o), 3));
		$display("test data path done");
		apb(1'b1, dsc_pkg::ADDR_MODE, 32'h2b);
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h073c0);
		repeat (2) @(posedge clk);
		chk({m2, m1}, 32'h2b);
		chk({sla, slb, sdo, fw, fa, fan}, 32'h3c);
		train <= 1'b1;
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h1f000);
		apb(1'b1, dsc_pkg::ADDR_ERR, 32'h7);
		repeat (50) @(posedge clk);
		chk(err, 1'b0);
		bad <= 1'b1;
		@(posedge clk);
		bad <= 1'b0;
		repeat (30) @(posedge clk);
		apb(1'b0, dsc_pkg::ADDR_ERR, 0); chk(rd[2:0], 32'h4);
		chk(err, 1'b1);
		apb(1'b1, dsc_pkg::ADDR_ERR, 32'h44);
		bad <= 1'b1;
		@(posedge clk);
		bad <= 1'b0;
		repeat (30) @(posedge clk);
		chk(err, 1'b0);
		train <= 1'b0;
		$display("test errors done");
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h207000);
		npulse = 0;
		sync <= 1'b1;
		repeat (8) @(posedge clk);
		chk(npulse, 1);
		chk(txen, 1'b1);
		apb(1'b0, dsc_pkg::ADDR_ERR, 0);
		chk(rd[2:0], 32'h2);
		sync <= 1'b0;
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h7400);
		npulse = 0;
		sync <= 1'b1;
		repeat (8) @(posedge clk);
		chk(npulse, 0);
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h7c00);
		repeat (8) @(posedge clk);
		chk(npulse, 1);
		chk(txen, 1'b1);
		apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h5000);
		sync <= 1'b0;
		repeat (8) @(posedge clk);
		npulse = 0;
		sync <= 1'b1;
		repeat (8) @(posedge clk);
		chk(npulse, 0);
		$display("test sync done");
		conclude();
	end
endmodule // dsc_top_tb
